// >>> vectored_interrupt_unit.sv
// Notes on behaviour
// R1: Six maskable, prioritised requests fed from nine sources.
// R2: Sources: four port pins, serial out, serial in, three timers.
// R3: Mask register enables all requests globally and each one individually.
// R4: Programmable priority encoder, ordered by priority register, picks the winner.
// R5: Grant disables further interrupts, saves PC and flags, vectors.
// R6: Each vector is two program bytes forming a 16-bit address.
// R7: Vector pairs at 0,1 up to 10,11, ascending by request.
// R8: Request register readable while masked, for polling.
// R9: Software setting a request bit raises that interrupt like hardware.
// R10: Sampled at instruction end; request must stand five clock periods before.
// R11: 48 clocks stacking, nine fetching, service routine starts on clock 58.
// R12: Pin two and pin one inputs have selectable rising or falling edge.
// R13: Pin three and pin zero inputs trigger only on falling edges.
// R14: Request zero and two combine handshake strobe, pin and timer.
// R15: Transmitted characters and timer zero raise four; timer one raises five.
// R16: Received characters raise request three, shared with pin zero.
// R17: Requests keep working while halted; any interrupt wakes the device.
// R18: Granting clears only the granted request's pending bit.
// R19: Masked edges still set pending; serviced once unmasked.
`timescale 1ns/10ps
`default_nettype none
`include "viu_map.svh"
module vectored_interrupt_unit
    import viu_pkg::*;
(
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    input  wire logic [7:0]  I_AXI_AWADDR,
    input  wire logic        I_AXI_AWVALID,
    output logic             O_AXI_AWREADY,
    input  wire logic [31:0] I_AXI_WDATA,
    input  wire logic [3:0]  I_AXI_WSTRB,
    input  wire logic        I_AXI_WVALID,
    output logic             O_AXI_WREADY,
    output logic [1:0]       O_AXI_BRESP,
    output logic             O_AXI_BVALID,
    input  wire logic        I_AXI_BREADY,
    input  wire logic [7:0]  I_AXI_ARADDR,
    input  wire logic        I_AXI_ARVALID,
    output logic             O_AXI_ARREADY,
    output logic [31:0]      O_AXI_RDATA,
    output logic [1:0]       O_AXI_RRESP,
    output logic             O_AXI_RVALID,
    input  wire logic        I_AXI_RREADY,
    input  wire logic        I_SERIAL_IN_EXT_PIN,
    input  wire logic        I_PIN_ONE_INPUT,
    input  wire logic        I_PIN_TWO_INPUT,
    input  wire logic        I_PIN_THREE_INPUT,
    input  wire logic        I_PORT_ZERO_HANDSHAKE_STROBE,
    input  wire logic        I_PORT_TWO_HANDSHAKE_STROBE,
    input  wire logic        I_TIMER_ZERO,
    input  wire logic        I_TIMER_ONE,
    input  wire logic        I_TIMER_TWO,
    input  wire logic        I_TIMER_IN_EVT,
    input  wire logic        I_SERIAL_TX_DONE,
    input  wire logic        I_SERIAL_RX_DONE,
    input  wire logic        I_INSTR_LAST,
    input  wire logic        I_HALTED,
    input  wire logic [7:0]  I_VEC_DATA,
    output logic             O_SAVE_CTX,
    output logic             O_VEC_RD,
    output logic [15:0]      O_VEC_ADDR,
    output logic             O_ISR_GO,
    output logic [15:0]      O_ISR_ADDR,
    output logic             O_BUSY,
    output logic             O_WAKE,
    output logic             O_IRQ
);
    viu_regs_t   r_q;
    viu_regs_t   r_d;
    logic [5:0]  hw_set;
    logic [5:0]  enabled;
    logic [5:0]  eligible;
    logic        p2_edge;
    logic        p1_edge;
    logic        fire;
    logic [2:0]  win;
    logic [2:0]  best_rank;
    logic        win_ok;
    logic        do_wr;
    logic        rd_take;
    logic [31:0] bm;
    logic [31:0] rd_mux;
    logic        rd_hit;
    logic        wr_hit;

    // R12: selectable edge
    assign p2_edge = r_q.edge_sel[0] ? (I_PIN_TWO_INPUT & ~r_q.pins_prev[2])
                                     : (~I_PIN_TWO_INPUT & r_q.pins_prev[2]);
    assign p1_edge = r_q.edge_sel[1] ? (I_PIN_ONE_INPUT & ~r_q.pins_prev[1])
                                     : (~I_PIN_ONE_INPUT & r_q.pins_prev[1]);

    // R1: six requests from nine sources
    // R2: pins, serial and timers
    // R14: shared request zero and two
    assign hw_set[0] = I_PORT_ZERO_HANDSHAKE_STROBE | p2_edge | I_TIMER_TWO;
    // R13: falling edge only
    assign hw_set[1] = ~I_PIN_THREE_INPUT & r_q.pins_prev[3];
    assign hw_set[2] = I_PORT_TWO_HANDSHAKE_STROBE | p1_edge | I_TIMER_IN_EVT;
    // R16: receiver shares with pin zero
    assign hw_set[3] = (~I_SERIAL_IN_EXT_PIN & r_q.pins_prev[0]) | I_SERIAL_RX_DONE;
    // R15: transmitter and timers
    assign hw_set[4] = I_SERIAL_TX_DONE | I_TIMER_ZERO;
    assign hw_set[5] = I_TIMER_ONE;

    // R3: global and individual enables
    assign enabled = r_q.mask[5:0] & {6{r_q.mask[`VIU_GIE_BIT]}};

    genvar gi;
    generate
        for (gi = 0; gi < `VIU_NREQ; gi++) begin : g_elig
            // R10: request must have stood long enough
            assign eligible[gi] = r_q.pend[gi] & enabled[gi] & (r_q.age[gi] >= `VIU_SETUP_CYC);
        end
    endgenerate

    // R4: lowest rank wins, ties go to lower index
    always_comb begin
        win       = 3'h0;
        best_rank = 3'h7;
        win_ok    = 1'b0;
        for (int i = 0; i < `VIU_NREQ; i++) begin
            if (eligible[i] && (!win_ok || r_q.prio[3*i +: 3] < best_rank)) begin
                win       = 3'(i);
                best_rank = r_q.prio[3*i +: 3];
                win_ok    = 1'b1;
            end
        end
    end

    // R10: sampled at the instruction's last cycle
    assign fire = I_INSTR_LAST & (r_q.st == ST_IDLE) & win_ok;

    assign do_wr   = r_q.aw_got & r_q.w_got & ~r_q.bvalid;
    assign rd_take = I_AXI_ARVALID & ~r_q.rvalid;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_bm
            assign bm[8*gi +: 8] = {8{r_q.wstrb[gi]}};
        end
    endgenerate

    function automatic logic [31:0] merge(input logic [31:0] old);
        merge = (r_q.wdata & bm) | (old & ~bm);
    endfunction : merge

    // R8: request register readable regardless of mask
    always_comb begin
        rd_hit = 1'b1;
        case (I_AXI_ARADDR)
            `VIU_OFF_REQ:      rd_mux = {26'h0, r_q.pend};
            `VIU_OFF_MASK:     rd_mux = {24'h0, r_q.mask};
            `VIU_OFF_PRIO:     rd_mux = {14'h0, r_q.prio};
            `VIU_OFF_EDGE:     rd_mux = {30'h0, r_q.edge_sel};
            `VIU_OFF_EVT:      rd_mux = {30'h0, r_q.evt};
            `VIU_OFF_EVT_MASK: rd_mux = {30'h0, r_q.evt_mask};
            `VIU_OFF_STAT:     rd_mux = {26'h0, I_HALTED, O_BUSY, 1'b0, r_q.cur};
            default: begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        case (r_q.awaddr)
            `VIU_OFF_REQ, `VIU_OFF_MASK, `VIU_OFF_PRIO, `VIU_OFF_EDGE,
            `VIU_OFF_EVT, `VIU_OFF_EVT_MASK, `VIU_OFF_STAT: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb begin
        r_d           = r_q;
        r_d.save      = 1'b0;
        r_d.go        = 1'b0;
        r_d.pins_prev = {I_PIN_THREE_INPUT, I_PIN_TWO_INPUT, I_PIN_ONE_INPUT,
                         I_SERIAL_IN_EXT_PIN};
        r_d.wake_prev = O_WAKE;

        // Address and data may arrive in either order
        if (I_AXI_AWVALID && O_AXI_AWREADY) begin
            r_d.aw_got = 1'b1;
            r_d.awaddr = I_AXI_AWADDR;
        end
        if (I_AXI_WVALID && O_AXI_WREADY) begin
            r_d.w_got = 1'b1;
            r_d.wdata = I_AXI_WDATA;
            r_d.wstrb = I_AXI_WSTRB;
        end
        if (r_q.bvalid && I_AXI_BREADY) begin
            r_d.bvalid = 1'b0;
        end
        if (do_wr) begin
            r_d.aw_got = 1'b0;
            r_d.w_got  = 1'b0;
            r_d.bvalid = 1'b1;
            r_d.bresp  = wr_hit ? `VIU_RESP_OKAY : `VIU_RESP_SLVERR;
            case (r_q.awaddr)
                // R9: software-set requests
                `VIU_OFF_REQ:      r_d.pend     = 6'(merge({26'h0, r_q.pend}));
                `VIU_OFF_MASK:     r_d.mask     = 8'(merge({24'h0, r_q.mask}));
                `VIU_OFF_PRIO:     r_d.prio     = 18'(merge({14'h0, r_q.prio}));
                `VIU_OFF_EDGE:     r_d.edge_sel = 2'(merge({30'h0, r_q.edge_sel}));
                `VIU_OFF_EVT_MASK: r_d.evt_mask = 2'(merge({30'h0, r_q.evt_mask}));
                default: ;
            endcase
        end

        if (r_q.rvalid && I_AXI_RREADY) begin
            r_d.rvalid = 1'b0;
        end
        if (rd_take) begin
            r_d.rvalid = 1'b1;
            r_d.rdata  = rd_mux;
            r_d.rresp  = rd_hit ? `VIU_RESP_OKAY : `VIU_RESP_SLVERR;
            if (I_AXI_ARADDR == `VIU_OFF_EVT) begin
                r_d.evt = 2'h0;
            end
        end

        case (r_q.st)
            ST_IDLE: begin
                if (fire) begin
                    // R5: grant closes the global enable
                    r_d.mask[`VIU_GIE_BIT] = 1'b0;
                    // R18: only the granted bit drops
                    r_d.pend[win] = 1'b0;
                    r_d.cur       = win;
                    r_d.save      = 1'b1;
                    r_d.st        = ST_STACK;
                    r_d.cnt       = `VIU_CNT_FIRST;
                    // R7: pair starts at twice the request number
                    r_d.vaddr     = {win, 1'b0};
                end
            end
            ST_STACK: begin
                // R11: stacking window
                r_d.cnt = 6'(r_q.cnt + `VIU_CNT_FIRST);
                if (r_q.cnt == `VIU_STACK_END) begin
                    r_d.st = ST_FETCH;
                end
            end
            ST_FETCH: begin
                r_d.cnt = 6'(r_q.cnt + `VIU_CNT_FIRST);
                // R6: high byte first, then low byte
                if (r_q.cnt == `VIU_HI_TAKE) begin
                    r_d.vec[15:8] = I_VEC_DATA;
                    r_d.vaddr     = 4'(r_q.vaddr + 4'h1);
                end
                if (r_q.cnt == `VIU_FETCH_END) begin
                    r_d.vec[7:0] = I_VEC_DATA;
                    r_d.go       = 1'b1;
                    r_d.st       = ST_IDLE;
                end
            end
            default: r_d.st = ST_IDLE;
        endcase

        // R19: sources set pending whatever the mask, and win over clears
        r_d.pend = r_d.pend | hw_set;
        for (int i = 0; i < `VIU_NREQ; i++) begin
            if (!r_d.pend[i]) begin
                r_d.age[i] = 3'h0;
            end else if (r_q.age[i] < `VIU_SETUP_CYC) begin
                r_d.age[i] = 3'(r_q.age[i] + 3'h1);
            end
        end

        // Event set wins over the read clear
        r_d.evt[`VIU_EVT_GRANT] = r_d.evt[`VIU_EVT_GRANT] | fire;
        r_d.evt[`VIU_EVT_WAKE]  = r_d.evt[`VIU_EVT_WAKE] | (O_WAKE & ~r_q.wake_prev);
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            r_q          <= '0;
            r_q.st       <= ST_IDLE;
            r_q.mask     <= `VIU_MASK_RST;
            r_q.prio     <= `VIU_PRIO_RST;
            r_q.edge_sel <= `VIU_EDGE_RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign O_AXI_AWREADY = ~r_q.aw_got & ~r_q.bvalid;
    assign O_AXI_WREADY  = ~r_q.w_got & ~r_q.bvalid;
    assign O_AXI_BVALID  = r_q.bvalid;
    assign O_AXI_BRESP   = r_q.bresp;
    assign O_AXI_ARREADY = ~r_q.rvalid;
    assign O_AXI_RVALID  = r_q.rvalid;
    assign O_AXI_RDATA   = r_q.rdata;
    assign O_AXI_RRESP   = r_q.rresp;
    assign O_SAVE_CTX    = r_q.save;
    assign O_VEC_RD      = (r_q.st == ST_FETCH);
    assign O_VEC_ADDR    = {12'h000, r_q.vaddr};
    assign O_ISR_GO      = r_q.go;
    assign O_ISR_ADDR    = r_q.vec;
    assign O_BUSY        = (r_q.st != ST_IDLE);
    // R17: any pending request ends the halt, masked or not
    assign O_WAKE        = I_HALTED & (|r_q.pend);
    assign O_IRQ         = |(r_q.evt & r_q.evt_mask);

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);

    sequence s_stack;
        (r_q.st == ST_STACK) [*8];
    endsequence
    sequence s_fetch_entry;
        ##40 (r_q.st == ST_STACK) ##1 (r_q.st == ST_FETCH);
    endsequence

    a_grant_closes_gie: assert property (fire |=> !r_q.mask[`VIU_GIE_BIT] && O_SAVE_CTX) // R5
        else $error("grant did not close global enable");
    a_stack_then_fetch: assert property (fire |=> s_stack ##0 s_fetch_entry) // R11
        else $error("stacking phase length wrong");
    a_isr_start_58: assert property (fire |-> ##58 O_ISR_GO) // R11
        else $error("service start not on clock 58");
    a_vector_pair: assert property (O_VEC_RD |-> O_VEC_ADDR[3:1] == r_q.cur && O_VEC_ADDR < 16'h000C) // R7
        else $error("vector address outside its pair");
    a_setup_gate: assert property (fire |-> r_q.age[win] >= `VIU_SETUP_CYC) // R10
        else $error("request taken before setup time");
    a_mask_gate: assert property (fire |-> r_q.mask[`VIU_GIE_BIT] && r_q.mask[win]) // R3
        else $error("masked request granted");
    a_pend_clear: assert property (fire && !hw_set[win] |=> !r_q.pend[$past(win)]) // R18
        else $error("granted pending bit not cleared");
    a_sw_set_req: assert property (do_wr && r_q.awaddr == `VIU_OFF_REQ && r_q.wstrb[0]
        && r_q.wdata[5] |=> r_q.pend[5]) // R9
        else $error("software set of request lost");
    a_pin_three_fall: assert property ($rose(I_PIN_THREE_INPUT) && !r_q.pend[1] && !do_wr
        |=> !r_q.pend[1]) // R13
        else $error("rising edge on pin three raised request");
    a_masked_pending: assert property (hw_set[4] |=> r_q.pend[4]) // R19
        else $error("source edge did not set pending");
endmodule : vectored_interrupt_unit
`default_nettype wire

// >>> viu_map.svh
`ifndef VIU_MAP_SVH
`define VIU_MAP_SVH
`define VIU_NREQ           6
`define VIU_OFF_REQ        8'h00
`define VIU_OFF_MASK       8'h04
`define VIU_OFF_PRIO       8'h08
`define VIU_OFF_EDGE       8'h0C
`define VIU_OFF_EVT        8'h10
`define VIU_OFF_EVT_MASK   8'h14
`define VIU_OFF_STAT       8'h18
`define VIU_GIE_BIT        7
`define VIU_MASK_RST       8'h00
`define VIU_PRIO_RST       18'h2C688
`define VIU_EDGE_RST       2'h0
`define VIU_CLK_PERIOD_NS  4
`define VIU_SETUP_PERIODS  5
`define VIU_SETUP_CYC      3'(`VIU_SETUP_PERIODS)
`define VIU_CNT_FIRST      6'h01
`define VIU_STACK_END      6'h30
`define VIU_HI_TAKE        6'h34
`define VIU_FETCH_END      6'h39
`define VIU_ISR_CYC        58
`define VIU_EVT_GRANT      0
`define VIU_EVT_WAKE       1
`define VIU_RESP_OKAY      2'h0
`define VIU_RESP_SLVERR    2'h2
`endif

// >>> viu_pkg.sv
`default_nettype none
package viu_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_STACK = 3'b010,
        ST_FETCH = 3'b100
    } viu_state_t;

    typedef struct packed {
        viu_state_t       st;
        logic [5:0]       pend;
        logic [5:0][2:0]  age;
        logic [7:0]       mask;
        logic [17:0]      prio;
        logic [1:0]       edge_sel;
        logic [1:0]       evt;
        logic [1:0]       evt_mask;
        logic [2:0]       cur;
        logic [5:0]       cnt;
        logic [3:0]       vaddr;
        logic [15:0]      vec;
        logic             save;
        logic             go;
        logic [3:0]       pins_prev;
        logic             wake_prev;
        logic             aw_got;
        logic             w_got;
        logic [7:0]       awaddr;
        logic [31:0]      wdata;
        logic [3:0]       wstrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } viu_regs_t;
endpackage : viu_pkg
`default_nettype wire

// >>> core_seq_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_seq_model #(
    parameter int INSTR_LEN = 7
) (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_vec_rd,
    input  wire logic [15:0] i_vec_addr,
    output logic             o_instr_last,
    output logic [7:0]       o_vec_data
);
    logic [7:0] cnt_q;
    logic [7:0] last_q;
    assign o_instr_last = (cnt_q == 8'(INSTR_LEN - 1));
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q  <= 8'h00;
            last_q <= 8'h00;
        end else begin
            cnt_q  <= o_instr_last ? 8'h00 : cnt_q + 8'h01;
            last_q <= o_vec_data;
        end
    end
    always_comb begin
        if (i_vec_rd && i_vec_addr < 16'h000C) begin
            o_vec_data = 8'h40 + 8'(i_vec_addr[3:0]) * 8'h11;
        end else begin
            // Bus released: never repeat the last byte
            o_vec_data = ~last_q;
        end
    end
endmodule : core_seq_model
`default_nettype wire

// >>> vectored_interrupt_unit_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "viu_map.svh"
module vectored_interrupt_unit_bench;
    import viu_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0]  pins = 4'h0;
    logic [7:0]  ev = 8'h00;
    logic        halted = 1'b0;
    logic        awready, wready, arready, bvalid, rvalid, save_ctx, vec_rd, isr_go;
    logic        busy, wake, irq, instr_last;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] vec_addr, isr_addr;
    logic [7:0]  vec_data;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          grants = 0;
    int          gos = 0;
    int          since = 0;
    int          gap = 0;
    int          evq [8] = '{0, 2, 4, 5, 0, 2, 4, 3};
    int          pq [4] = '{3, 2, 0, 1};

    always #2 clk = ~clk;
    // Grants can start while a bus task is still busy, so watch them here
    always @(posedge clk) begin
        if (save_ctx === 1'b1) begin
            grants <= grants + 1;
            since  <= 1;
        end else begin
            since <= since + 1;
        end
        if (isr_go === 1'b1) begin
            gos <= gos + 1;
            gap <= since;
        end
    end

    vectored_interrupt_unit DUT (
        .I_CLK(clk), .I_RSTN(rstn),
        .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
        .I_AXI_WDATA(wdata), .I_AXI_WSTRB(4'hF), .I_AXI_WVALID(wvalid), .O_AXI_WREADY(wready),
        .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
        .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready),
        .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready),
        .I_SERIAL_IN_EXT_PIN(pins[0]), .I_PIN_ONE_INPUT(pins[1]),
        .I_PIN_TWO_INPUT(pins[2]), .I_PIN_THREE_INPUT(pins[3]),
        .I_PORT_ZERO_HANDSHAKE_STROBE(ev[0]), .I_PORT_TWO_HANDSHAKE_STROBE(ev[1]),
        .I_TIMER_ZERO(ev[2]), .I_TIMER_ONE(ev[3]), .I_TIMER_TWO(ev[4]),
        .I_TIMER_IN_EVT(ev[5]), .I_SERIAL_TX_DONE(ev[6]), .I_SERIAL_RX_DONE(ev[7]),
        .I_INSTR_LAST(instr_last), .I_HALTED(halted), .I_VEC_DATA(vec_data),
        .O_SAVE_CTX(save_ctx), .O_VEC_RD(vec_rd), .O_VEC_ADDR(vec_addr), .O_ISR_GO(isr_go),
        .O_ISR_ADDR(isr_addr), .O_BUSY(busy), .O_WAKE(wake), .O_IRQ(irq)
    );

    core_seq_model #(.INSTR_LEN(7)) core_model (
        .i_clk(clk), .i_rstn(rstn), .i_vec_rd(vec_rd), .i_vec_addr(vec_addr),
        .o_instr_last(instr_last), .o_vec_data(vec_data)
    );

    task automatic results();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Readies sampled mid-cycle: the value that the next rising edge sees
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic       ha, hw, hb;
        logic [1:0] r;
        int         n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        hb = 1'b0;
        r = 2'h3;
        for (n = 0; !hb && n < 100; n++) begin
            @(negedge clk);
            ha = awvalid & awready;
            hw = wvalid & wready;
            hb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic        ha, hr;
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        hr = 1'b0;
        for (n = 0; !hr && n < 100; n++) begin
            @(negedge clk);
            ha = arvalid & arready;
            hr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
        @(posedge clk);
    endtask : rd

    task automatic req_is(input logic [5:0] e);
        repeat (3) @(posedge clk);
        rd(`VIU_OFF_REQ, {26'h0, e}, 2'h0);
        wr(`VIU_OFF_REQ, 32'h00000000, 2'h0);
    endtask : req_is

    task automatic grant_chk(input int n, input int g);
        int c;
        for (c = 0; gos < g && c < 400; c++) @(negedge clk);
        chk(32'(gos), 32'(g));
        chk(32'(gap), 32'h00000039);
        chk({16'h0, isr_addr}, {16'h0, 8'h40 + 8'(34 * n), 8'h51 + 8'(34 * n)});
        @(posedge clk);
    endtask : grant_chk

    initial begin
        #40000;
        error_cnt++;
        results();
    end

    initial begin
        logic [5:0] b;
        logic       rs;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(`VIU_OFF_PRIO, 32'h0002C688, 2'h0);
        rd(`VIU_OFF_MASK, 32'h00000000, 2'h0);
        rd(8'h40, 32'h00000000, 2'h2);
        wr(8'h40, 32'hFFFFFFFF, 2'h2);
        wr(`VIU_OFF_REQ, 32'h00000015, 2'h0);
        rd(`VIU_OFF_REQ, 32'h00000015, 2'h0);
        wr(`VIU_OFF_REQ, 32'h00000000, 2'h0);
        for (int k = 0; k < 8; k++) begin
            ev[k] <= 1'b1;
            @(posedge clk);
            ev[k] <= 1'b0;
            req_is(6'h01 << evq[k]);
        end
        for (int e = 0; e < 2; e++) begin
            wr(`VIU_OFF_EDGE, e ? 32'h00000003 : 32'h00000000, 2'h0);
            for (int i = 0; i < 4; i++) begin
                b = 6'h01 << pq[i];
                rs = (e == 1) && (i == 1 || i == 2);
                pins[i] <= 1'b1;
                req_is(rs ? b : 6'h00);
                pins[i] <= 1'b0;
                req_is(rs ? 6'h00 : b);
            end
        end
        // Halted core: timer still counts and wakes it
        wr(`VIU_OFF_EVT_MASK, 32'h00000002, 2'h0);
        halted <= 1'b1;
        ev[3] <= 1'b1;
        @(posedge clk);
        ev[3] <= 1'b0;
        repeat (3) @(negedge clk);
        chk({30'h0, wake, irq}, 32'h00000003);
        @(posedge clk);
        rd(`VIU_OFF_EVT, 32'h00000002, 2'h0);
        wr(`VIU_OFF_REQ, 32'h00000000, 2'h0);
        halted <= 1'b0;
        wr(`VIU_OFF_EVT_MASK, 32'h00000001, 2'h0);
        for (int n = 0; n < 6; n++) begin
            // Request n alone holds rank 0, all six pending
            wr(`VIU_OFF_PRIO, 32'(18'h3FFFF ^ (18'h7 << (3 * n))), 2'h0);
            wr(`VIU_OFF_REQ, 32'h0000003F, 2'h0);
            wr(`VIU_OFF_MASK, 32'h000000BF, 2'h0);
            grant_chk(n, n + 1);
            @(negedge clk);
            chk({31'h0, irq}, 32'h00000001);
            @(posedge clk);
            rd(`VIU_OFF_EVT, 32'h00000001, 2'h0);
            @(negedge clk);
            chk({31'h0, irq}, 32'h00000000);
            @(posedge clk);
            rd(`VIU_OFF_MASK, 32'h0000003F, 2'h0);
            rd(`VIU_OFF_REQ, 32'(6'h3F & ~(6'h01 << n)), 2'h0);
            rd(`VIU_OFF_STAT, 32'(n), 2'h0);
            wr(`VIU_OFF_REQ, 32'h00000000, 2'h0);
        end
        wr(`VIU_OFF_MASK, 32'h0000003F, 2'h0);
        pins[3] <= 1'b1;
        @(posedge clk);
        pins[3] <= 1'b0;
        repeat (3) @(posedge clk);
        rd(`VIU_OFF_REQ, 32'h00000002, 2'h0);
        repeat (40) @(posedge clk);
        chk(32'(grants), 32'h00000006);
        wr(`VIU_OFF_MASK, 32'h00000080, 2'h0);
        repeat (40) @(posedge clk);
        chk(32'(grants), 32'h00000006);
        wr(`VIU_OFF_MASK, 32'h00000082, 2'h0);
        grant_chk(1, 7);
        results();
    end
endmodule : vectored_interrupt_unit_bench
`default_nettype wire
